// >>> inc/tcm_pkg.sv
// Constants, command and result codes and the state record of the
// transaction commit manager.
// Assumes a 32-bit APB slave port with byte addresses in paddr[7:0].
package tcm_pkg;

    localparam int TCM_AW = 8;

    // Register byte offsets, one aligned 32-bit word each.
    localparam logic [7:0] TCM_OFF_CMD = 8'h00;
    localparam logic [7:0] TCM_OFF_ARG = 8'h04;
    localparam logic [7:0] TCM_OFF_CFG = 8'h08;
    localparam logic [7:0] TCM_OFF_STATUS = 8'h0c;
    localparam logic [7:0] TCM_OFF_CEILING = 8'h10;
    localparam logic [7:0] TCM_OFF_COUNTER = 8'h14;
    localparam logic [7:0] TCM_OFF_MAC_IN = 8'h18;
    localparam logic [7:0] TCM_OFF_MAC_FILE = 8'h1c;
    localparam logic [7:0] TCM_OFF_RID_CUR = 8'h20;
    localparam logic [7:0] TCM_OFF_RID_PREV = 8'h24;
    localparam logic [7:0] TCM_OFF_VALUE = 8'h28;
    localparam logic [7:0] TCM_OFF_RECORD = 8'h2c;
    localparam logic [7:0] TCM_OFF_SES_NV = 8'h30;

    // Field positions.
    localparam int TCM_CMD_OPT_BIT = 8;
    localparam int TCM_CMD_PROT_BIT = 9;
    localparam int TCM_CFG_MAC_FILE_BIT = 0;
    localparam int TCM_CFG_LWC_BIT = 1;
    localparam int TCM_CFG_RID_REQ_BIT = 2;

    // Values after reset.
    localparam logic [31:0] TCM_WORD_RST = 32'h0000_0000;
    localparam logic [15:0] TCM_HALF_RST = 16'h0000;
    localparam logic [7:0] TCM_SEQ_RST = 8'h00;

    typedef enum logic [3:0] {
        TCM_NO_COMMAND = 4'h0,
        TCM_SELECT_FILE_CMD = 4'h1,
        TCM_CANCEL_COMMAND = 4'h2,
        TCM_FINALIZE_COMMAND = 4'h3,
        TCM_AUTH_COMMAND = 4'h4,
        TCM_READER_IDENTITY_COMMIT_CMD = 4'h5,
        TCM_VALUE_WRITE_CMD = 4'h6,
        TCM_RECORD_WRITE_CMD = 4'h7,
        TCM_FILE_READ_CMD = 4'h8
    } tcm_cmd_t;

    typedef enum logic [2:0] {
        TCM_RES_OK = 3'h0,
        TCM_RES_NO_APP = 3'h1,
        TCM_RES_NO_CHANGE = 3'h2,
        TCM_RES_NO_MAC_FILE = 3'h3,
        TCM_RES_LOCKED = 3'h4,
        TCM_RES_NO_READER = 3'h5,
        TCM_RES_PROTOCOL = 3'h6,
        TCM_RES_FAILED = 3'h7
    } tcm_res_t;

    typedef enum logic [1:0] {
        TCM_IDLE = 2'b00,
        TCM_EXEC = 2'b01,
        TCM_COMMIT = 2'b11
    } tcm_phase_t;

    typedef struct packed {
        tcm_phase_t st;
        tcm_cmd_t cmd;
        logic opt;
        logic prot;
        logic [31:0] arg;
        tcm_res_t result;
        logic resp_mac;
        logic app_sel;
        logic auth;
        logic mac_file;
        logic lwc;
        logic rid_req;
        logic [31:0] ceiling;
        logic [31:0] counter;
        logic [15:0] ses_nv;
        logic [31:0] mac_in;
        logic [31:0] mac_val;
        logic [31:0] rid_cur;
        logic rid_valid;
        logic rid_auth;
        logic [31:0] rid_prev;
        logic [31:0] val_shadow;
        logic [31:0] val_file;
        logic val_pend;
        logic [31:0] rec_shadow;
        logic [31:0] rec_file;
        logic rec_pend;
        logic mac_input_stream;
        logic [7:0] txn_seq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tcm_regs_t;

endpackage : tcm_pkg

// >>> verilog/tcm_transaction_commit_manager.sv
// Transaction commit manager of a contactless card, reached over APB.
// Assumes a single clock, APB master behaviour per the bus protocol and
// that the MAC arithmetic is done elsewhere and written into MAC_IN.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps

// Functional notes
// - Application select starts a fresh transaction.
// - Any conclusion starts a new transaction at once.
// - Successful authentication leaves the transaction untouched.
// - MAC response option needs a MAC file.
// - Commit makes value and record writes permanent.
// - Commit stores MAC value and incremented counter.
// - Cipher mode: write both parts, clear session part.
// - Counter at ceiling blocks data commands.
// - Commit updates everything in one atomic step.
// - Commit without selected application is rejected.
// - Commit with nothing pending is rejected.
// - Required reader identity missing rejects commit when a MAC file is used.
// - Previous identity updates only if committed authenticated.
// - Authenticated commit must be MAC protected.
// - Failed command or reselect aborts the transaction.
// - Counter is four bytes, least significant first.
// - Cancel discards pending writes, keeps authentication.
module tcm_transaction_commit_manager
    import tcm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TCM_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    tcm_regs_t r_reg;
    tcm_regs_t r_next;
    logic locked;

    // Ends the current transaction: shadows, MAC input and identity go.
    function automatic tcm_regs_t tcm_new_txn(input tcm_regs_t s);
        tcm_regs_t t;
        t = s;
        t.val_pend = 1'b0;
        t.rec_pend = 1'b0;
        t.mac_input_stream = 1'b0;
        t.rid_valid = 1'b0;
        t.rid_auth = 1'b0;
        t.txn_seq = s.txn_seq + 8'h01;
        return t;
    endfunction : tcm_new_txn

    function automatic logic tcm_mapped(input logic [TCM_AW-1:0] a);
        return a <= TCM_OFF_SES_NV && a[1:0] == 2'b00;
    endfunction : tcm_mapped

    // Ceiling of zero means the limit is not enabled.
    assign locked = r_reg.mac_file && r_reg.ceiling != TCM_WORD_RST &&
        r_reg.counter >= r_reg.ceiling;

    always_comb begin
        tcm_regs_t n;
        tcm_res_t res;
        logic wr_done;
        n = r_reg;
        res = TCM_RES_OK;
        wr_done = psel && penable && pready && pwrite;

        // One wait state: pready rises one cycle into the access phase.
        n.pready = psel && penable && !r_reg.pready;
        n.pslverr = psel && penable && !r_reg.pready && !tcm_mapped(paddr);
        n.prdata = TCM_WORD_RST;
        if (psel && penable && !r_reg.pready) begin
            unique case (paddr)
                TCM_OFF_CMD: n.prdata = {22'h0, r_reg.prot, r_reg.opt,
                    2'h0, r_reg.st, r_reg.cmd};
                TCM_OFF_ARG: n.prdata = r_reg.arg;
                TCM_OFF_CFG: n.prdata = {29'h0, r_reg.rid_req, r_reg.lwc,
                    r_reg.mac_file};
                TCM_OFF_STATUS: n.prdata = {8'h0, r_reg.txn_seq, 4'h0,
                    r_reg.resp_mac, r_reg.rid_valid, r_reg.mac_input_stream,
                    r_reg.rec_pend, r_reg.val_pend, locked, r_reg.auth,
                    r_reg.app_sel, r_reg.st != TCM_IDLE, r_reg.result};
                TCM_OFF_CEILING: n.prdata = r_reg.ceiling;
                TCM_OFF_COUNTER: n.prdata = r_reg.counter;
                TCM_OFF_MAC_IN: n.prdata = r_reg.mac_in;
                TCM_OFF_MAC_FILE: n.prdata = r_reg.mac_val;
                TCM_OFF_RID_CUR: n.prdata = r_reg.rid_cur;
                TCM_OFF_RID_PREV: n.prdata = r_reg.rid_prev;
                TCM_OFF_VALUE: n.prdata = r_reg.val_file;
                TCM_OFF_RECORD: n.prdata = r_reg.rec_file;
                TCM_OFF_SES_NV: n.prdata = {16'h0, r_reg.ses_nv};
                default: n.prdata = TCM_WORD_RST;
            endcase
        end

        // Commands written while one is in flight are dropped.
        if (wr_done) begin
            unique case (paddr)
                TCM_OFF_CMD: begin
                    if (r_reg.st == TCM_IDLE) begin
                        n.st = TCM_EXEC;
                        n.cmd = tcm_cmd_t'(pwdata[3:0]);
                        n.opt = pwdata[TCM_CMD_OPT_BIT];
                        n.prot = pwdata[TCM_CMD_PROT_BIT];
                    end
                end
                TCM_OFF_ARG: n.arg = pwdata;
                TCM_OFF_CFG: begin
                    n.mac_file = pwdata[TCM_CFG_MAC_FILE_BIT];
                    n.lwc = pwdata[TCM_CFG_LWC_BIT];
                    n.rid_req = pwdata[TCM_CFG_RID_REQ_BIT];
                    // A configuration change aborts the transaction.
                    if (pwdata[2:0] != {r_reg.rid_req, r_reg.lwc,
                        r_reg.mac_file}) begin
                        n = tcm_new_txn(n);
                    end
                end
                TCM_OFF_CEILING: n.ceiling = pwdata;
                TCM_OFF_MAC_IN: n.mac_in = pwdata;
                default: n.arg = r_reg.arg;
            endcase
        end

        unique case (r_reg.st)
            TCM_IDLE: begin
                n.st = n.st;
            end
            TCM_EXEC: begin
                n.st = TCM_IDLE;
                n.resp_mac = 1'b0;
                unique case (r_reg.cmd)
                    TCM_SELECT_FILE_CMD: begin
                        // Option set selects the card-level directory.
                        n.app_sel = !r_reg.opt;
                        n.auth = 1'b0;
                        n = tcm_new_txn(n);
                    end
                    TCM_AUTH_COMMAND: begin
                        // Transaction state is left alone on success; a failed attempt (option clear) aborts it.
                        n.auth = r_reg.opt;
                        if (!r_reg.opt) begin
                            res = TCM_RES_FAILED;
                        end
                    end
                    TCM_CANCEL_COMMAND: begin
                        if (!r_reg.app_sel) begin
                            res = TCM_RES_NO_APP;
                        end else if (r_reg.auth && !r_reg.prot) begin
                            res = TCM_RES_PROTOCOL;
                        end else if (!(r_reg.val_pend || r_reg.rec_pend ||
                            r_reg.mac_input_stream)) begin
                            res = TCM_RES_NO_CHANGE;
                        end else begin
                            n = tcm_new_txn(n);
                        end
                    end
                    TCM_FINALIZE_COMMAND: begin
                        if (!r_reg.app_sel) begin
                            res = TCM_RES_NO_APP;
                        end else if (r_reg.auth && !r_reg.prot) begin
                            res = TCM_RES_PROTOCOL;
                        end else if (r_reg.opt && !r_reg.mac_file) begin
                            res = TCM_RES_NO_MAC_FILE;
                        end else if (r_reg.mac_file && r_reg.rid_req &&
                            !r_reg.rid_valid) begin
                            res = TCM_RES_NO_READER;
                        end else if (!(r_reg.val_pend || r_reg.rec_pend ||
                            r_reg.mac_input_stream)) begin
                            res = TCM_RES_NO_CHANGE;
                        end else begin
                            n.st = TCM_COMMIT;
                        end
                    end
                    TCM_READER_IDENTITY_COMMIT_CMD: begin
                        if (!r_reg.app_sel) begin
                            res = TCM_RES_NO_APP;
                        end else if (locked) begin
                            res = TCM_RES_LOCKED;
                        end else begin
                            n.rid_cur = r_reg.arg;
                            n.rid_valid = 1'b1;
                            n.rid_auth = r_reg.auth;
                            n.mac_input_stream = r_reg.mac_file;
                        end
                    end
                    TCM_VALUE_WRITE_CMD, TCM_RECORD_WRITE_CMD: begin
                        if (!r_reg.app_sel) begin
                            res = TCM_RES_NO_APP;
                        end else if (locked) begin
                            res = TCM_RES_LOCKED;
                        end else if (r_reg.cmd == TCM_VALUE_WRITE_CMD) begin
                            n.val_shadow = r_reg.arg;
                            n.val_pend = 1'b1;
                            n.mac_input_stream = n.mac_input_stream || r_reg.mac_file;
                        end else begin
                            n.rec_shadow = r_reg.arg;
                            n.rec_pend = 1'b1;
                            n.mac_input_stream = n.mac_input_stream || r_reg.mac_file;
                        end
                    end
                    TCM_FILE_READ_CMD: begin
                        // Option set means the read targets the MAC file.
                        if (!r_reg.app_sel) begin
                            res = TCM_RES_NO_APP;
                        end else if (locked && !r_reg.opt) begin
                            res = TCM_RES_LOCKED;
                        end else begin
                            n.mac_input_stream = r_reg.mac_input_stream || r_reg.mac_file;
                        end
                    end
                    default: res = TCM_RES_FAILED;
                endcase
                n.result = res;
                if (res != TCM_RES_OK && r_reg.app_sel) begin
                    n = tcm_new_txn(n);
                end
            end
            TCM_COMMIT: begin
                // Every permanent update lands on this one edge, so a
                // torn supply sees all of them or none.
                n.st = TCM_IDLE;
                if (r_reg.val_pend) begin
                    n.val_file = r_reg.val_shadow;
                end
                if (r_reg.rec_pend) begin
                    n.rec_file = r_reg.rec_shadow;
                end
                if (r_reg.mac_file && r_reg.mac_input_stream) begin
                    n.mac_val = r_reg.mac_in;
                    if (r_reg.lwc) begin
                        // Upper half is the actual part, lower the session.
                        n.counter = {r_reg.counter[31:16],
                            r_reg.ses_nv + 16'h0001};
                        n.ses_nv = TCM_HALF_RST;
                    end else begin
                        n.counter = r_reg.counter + 32'h0000_0001;
                    end
                end
                if (r_reg.rid_valid && r_reg.rid_auth) begin
                    n.rid_prev = r_reg.rid_cur;
                end
                n.resp_mac = r_reg.opt;
                n.result = TCM_RES_OK;
                n = tcm_new_txn(n);
            end
            default: n.st = TCM_IDLE;
        endcase
        r_next = n;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_wait_state_a: assert property (psel && penable && !pready
        |=> pready ##1 !pready) else $error("pready timing wrong");
    commit_no_app_a: assert property (
        r_reg.st == TCM_EXEC && r_reg.cmd == TCM_FINALIZE_COMMAND &&
        !r_reg.app_sel |=> r_reg.result == TCM_RES_NO_APP &&
        r_reg.st == TCM_IDLE) else $error("commit without app taken");
    commit_mac_opt_a: assert property (
        r_reg.st == TCM_EXEC && r_reg.cmd == TCM_FINALIZE_COMMAND &&
        r_reg.opt && !r_reg.mac_file |=> r_reg.st == TCM_IDLE &&
        r_reg.result != TCM_RES_OK) else $error("mac option not refused");
    commit_empty_a: assert property (
        r_reg.st == TCM_EXEC && r_reg.cmd == TCM_FINALIZE_COMMAND &&
        !r_reg.val_pend && !r_reg.rec_pend && !r_reg.mac_input_stream
        |=> r_reg.st == TCM_IDLE &&
        r_reg.result != TCM_RES_OK) else $error("empty commit accepted");
    commit_files_a: assert property (
        r_reg.st == TCM_COMMIT && r_reg.val_pend
        |=> r_reg.val_file == $past(r_reg.val_shadow) && !r_reg.val_pend)
        else $error("value file not committed");
    commit_new_txn_a: assert property (
        r_reg.st == TCM_COMMIT |=> r_reg.st == TCM_IDLE &&
        r_reg.txn_seq == $past(r_reg.txn_seq) + 8'h01)
        else $error("no new transaction after commit");
    mac_update_a: assert property (
        r_reg.st == TCM_COMMIT && r_reg.mac_file && r_reg.mac_input_stream &&
        !r_reg.lwc |=> r_reg.mac_val == $past(r_reg.mac_in) &&
        r_reg.counter == $past(r_reg.counter) + 32'h0000_0001)
        else $error("mac file not updated");
    prev_reader_a: assert property (
        r_reg.st == TCM_COMMIT && !r_reg.rid_auth
        |=> $stable(r_reg.rid_prev)) else $error("prev identity changed");
    auth_keeps_a: assert property (
        r_reg.st == TCM_EXEC && r_reg.cmd == TCM_AUTH_COMMAND && r_reg.opt
        |=> $stable(r_reg.txn_seq) && r_reg.auth)
        else $error("auth disturbed transaction");
    locked_write_a: assert property (
        r_reg.st == TCM_EXEC && r_reg.cmd == TCM_VALUE_WRITE_CMD &&
        r_reg.app_sel && locked |=> r_reg.result == TCM_RES_LOCKED &&
        !r_reg.val_pend) else $error("write passed at ceiling");
    unprot_commit_a: assert property (
        r_reg.st == TCM_EXEC && r_reg.cmd == TCM_FINALIZE_COMMAND &&
        r_reg.app_sel && r_reg.auth && !r_reg.prot
        |=> r_reg.result == TCM_RES_PROTOCOL) else $error("unprotected ok");

endmodule : tcm_transaction_commit_manager

// >>> tb/tcm_reader_model.sv
// Reader-side APB master: turns card commands into register accesses.
// Assumes one clock shared with the card and a slave that raises pready.
`timescale 1ns/1ps
module tcm_reader_model
    import tcm_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [TCM_AW-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Idle cycles before the setup let the reader act slowly.
    task automatic xfer(input logic w, input logic [TCM_AW-1:0] a,
        input logic [31:0] d, input int gap, output logic [31:0] q,
        output logic e);
        repeat (gap + 1) @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse so stale values never pass.
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : tcm_reader_model

// >>> tb/tb_transaction_commit_manager.sv
// Bench for the transaction commit manager: a reader model issues card
// commands over APB and an integer model predicts status and files.
// Assumes results are polled from STATUS until busy clears.
`timescale 1ns/1ps
module tb_transaction_commit_manager;
    import tcm_pkg::*;

    // Every status bit is compared; the mask is kept for narrower checks.
    localparam logic [31:0] M = 32'hffff_ffff;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [TCM_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] q;
    logic e;
    logic [31:0] d1, d2;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int app = 0, auth = 0, vp = 0, rp = 0, mac_input_stream = 0, rv = 0, ra = 0;
    int seq = 0, mac = 0, lwc = 0, rreq = 0, res = 0, rm = 0;
    logic [31:0] ceil = '0, cnt = '0, vsh = '0, rsh = '0, vf = '0;
    logic [31:0] rf = '0, rcur = '0, rprev = '0, macin = '0;

    tcm_transaction_commit_manager uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );
    tcm_reader_model m (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    task automatic check_word(string nm, logic [31:0] x, logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : check_word

    task automatic check_bit(string nm, logic x, logic g);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("wrong value %s expected %b seen %b", nm, x, g);
        end
    endtask : check_bit

    task automatic wr(logic [TCM_AW-1:0] a, logic [31:0] d);
        m.xfer(1'b1, a, d, $urandom_range(2), q, e);
    endtask : wr

    task automatic rd(logic [TCM_AW-1:0] a);
        m.xfer(1'b0, a, 32'h0, $urandom_range(2), q, e);
    endtask : rd

    function automatic logic [31:0] stat();
        logic lk;
        lk = mac != 0 && ceil != 0 && cnt >= ceil;
        return {8'h00, seq[7:0], 4'h0, rm[0], rv[0], mac_input_stream[0], rp[0], vp[0], lk,
            auth[0], app[0], 1'b0, res[2:0]};
    endfunction : stat

    task automatic newtx();
        vp = 0;
        rp = 0;
        mac_input_stream = 0;
        rv = 0;
        seq++;
    endtask : newtx

    // Any change of the configuration aborts the transaction.
    task automatic setcfg(logic [2:0] v);
        wr(TCM_OFF_CFG, 32'(v));
        if (v != {rreq[0], lwc[0], mac[0]}) newtx();
        mac = v[0];
        lwc = v[1];
        rreq = v[2];
    endtask : setcfg

    task automatic cmd(int c, int o, int p, logic [31:0] a, logic [31:0] k);
        logic lk;
        lk = mac != 0 && ceil != 0 && cnt >= ceil;
        wr(TCM_OFF_ARG, a);
        wr(TCM_OFF_CMD, 32'(c) | (32'(o) << TCM_CMD_OPT_BIT)
            | (32'(p) << TCM_CMD_PROT_BIT));
        do rd(TCM_OFF_STATUS); while (q[3] !== 1'b0);
        res = 0;
        rm = 0;
        case (c)
            1: begin
                auth = 0;
                newtx();
                app = (o == 0);
            end
            2: begin
                if (app == 0) res = 1;
                else if (auth != 0 && p == 0) res = 6;
                else if (vp + rp + mac_input_stream == 0) res = 2;
            end
            3: begin
                if (app == 0) res = 1;
                else if (auth != 0 && p == 0) res = 6;
                else if (o != 0 && mac == 0) res = 3;
                else if (mac != 0 && rreq != 0 && rv == 0) res = 5;
                else if (vp + rp + mac_input_stream == 0) res = 2;
                else begin
                    rm = o;
                    if (vp != 0) vf = vsh;
                    if (rp != 0) rf = rsh;
                    if (mac != 0 && mac_input_stream != 0) begin
                        if (lwc != 0) cnt = {cnt[31:16], 16'h0001};
                        else cnt = cnt + 1;
                    end
                    if (rv != 0 && ra != 0) rprev = rcur;
                    newtx();
                end
            end
            4: begin
                auth = o;
                res = (o != 0) ? 0 : 7;
            end
            default: begin
                if (app == 0) res = 1;
                else if (lk && !(c == 8 && o != 0)) res = 4;
                else begin
                    if (mac != 0) mac_input_stream = 1;
                    if (c == 5) begin
                        rv = 1;
                        rcur = a;
                        ra = auth;
                    end
                    if (c == 6) vp = 1;
                    if (c == 6) vsh = a;
                    if (c == 7) rp = 1;
                    if (c == 7) rsh = a;
                end
            end
        endcase
        if (app != 0 && (c == 2 || res != 0)) newtx();
        check_word("status", stat() & k, q & k);
    endtask : cmd

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        presetn = 1'b0;
        void'($urandom(32'h6a8ba94a));
        d1 = $urandom;
        d2 = $urandom;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(TCM_OFF_STATUS);
        check_word("reset status", 32'h0, q);
        rd(8'h34);
        check_bit("pslverr", 1'b1, e);
        cmd(3, 0, 0, 0, M);
        cmd(1, 0, 0, 0, M);
        cmd(3, 0, 0, 0, M);
        cmd(2, 0, 0, 0, M);
        $display("selection test done");
        cmd(6, 0, 0, d1, M);
        rd(TCM_OFF_VALUE);
        check_word("value", vf, q);
        cmd(2, 0, 0, 0, M);
        rd(TCM_OFF_VALUE);
        check_word("value", vf, q);
        cmd(6, 0, 0, d1, M);
        cmd(4, 1, 0, 0, M);
        cmd(7, 0, 1, d2, M);
        cmd(3, 0, 0, 0, M);
        cmd(1, 1, 0, 0, M);
        cmd(1, 0, 0, 0, M);
        cmd(4, 1, 0, 0, M);
        cmd(6, 0, 1, d2, M);
        cmd(7, 0, 1, d1, M);
        cmd(3, 0, 1, 0, M);
        rd(TCM_OFF_VALUE);
        check_word("value", vf, q);
        rd(TCM_OFF_RECORD);
        check_word("record", rf, q);
        cmd(4, 0, 1, 0, M);
        $display("backup file test done");
        cmd(1, 1, 0, 0, M);
        cmd(1, 0, 0, 0, M);
        cmd(6, 0, 0, d1, M);
        cmd(3, 1, 0, 0, M);
        cmd(1, 1, 0, 0, M);
        setcfg(3'h1);
        cmd(1, 0, 0, 0, M);
        cmd(8, 0, 0, 0, M);
        macin = $urandom;
        wr(TCM_OFF_MAC_IN, macin);
        cmd(3, 1, 0, 0, M);
        rd(TCM_OFF_COUNTER);
        check_word("counter", cnt, q);
        rd(TCM_OFF_MAC_FILE);
        check_word("mac file", macin, q);
        $display("mac test done");
        cmd(1, 1, 0, 0, M);
        setcfg(3'h5);
        cmd(1, 0, 0, 0, M);
        cmd(8, 0, 0, 0, M);
        cmd(3, 0, 0, 0, M);
        cmd(5, 0, 0, d1, M);
        rd(TCM_OFF_RID_CUR);
        check_word("current identity", rcur, q);
        cmd(3, 0, 0, 0, M);
        rd(TCM_OFF_RID_PREV);
        check_word("prev identity", rprev, q);
        cmd(4, 1, 0, 0, M);
        cmd(5, 0, 1, d2, M);
        cmd(3, 0, 1, 0, M);
        rd(TCM_OFF_RID_PREV);
        check_word("prev identity", rprev, q);
        cmd(4, 0, 1, 0, M);
        $display("identity test done");
        cmd(1, 1, 0, 0, M);
        setcfg(3'h3);
        cmd(1, 0, 0, 0, M);
        cmd(8, 0, 0, 0, M);
        cmd(3, 0, 0, 0, M);
        cmd(1, 1, 0, 0, M);
        rd(TCM_OFF_COUNTER);
        check_word("counter", cnt, q);
        rd(TCM_OFF_SES_NV);
        check_word("session part", 32'h0, q);
        $display("cipher mode test done");
        setcfg(3'h1);
        ceil = cnt;
        wr(TCM_OFF_CEILING, cnt);
        cmd(1, 0, 0, 0, M);
        cmd(6, 0, 0, d1, M);
        cmd(8, 1, 0, 0, M);
        cmd(5, 0, 0, d1, M);
        $display("ceiling test done");
        finish_test();
    end
endmodule : tb_transaction_commit_manager
